// *** bench/node_host.sv ***
// host model: axi4-lite master with one write and one read task
// assumes tasks are called right after a rising aclk edge
`timescale 1ns/1ps
module node_host (
  // clock
  input  wire logic        aclk,
  // write channels
  output      logic [7:0]  awaddr,
  output      logic        awvalid,
  input  wire logic        awready,
  output      logic [31:0] wdata,
  output      logic [3:0]  wstrb,
  output      logic        wvalid,
  input  wire logic        wready,
  input  wire logic [1:0]  bresp,
  input  wire logic        bvalid,
  output      logic        bready,
  // read channels
  output      logic [7:0]  araddr,
  output      logic        arvalid,
  input  wire logic        arready,
  input  wire logic [31:0] rdata,
  input  wire logic [1:0]  rresp,
  input  wire logic        rvalid,
  output      logic        rready
);
  initial
  begin
    {awaddr, araddr, wdata} = '0;
    {awvalid, wvalid, arvalid} = 3'h0;
    {bready, rready} = 2'h3;
    wstrb = 4'h1;
  end

  // handshake seen before the edge, released just after it
  task automatic wr(input logic [7:0] a, input logic [7:0] d, output logic [1:0] r);
    logic aw_go;
    logic w_go;
    logic b_go;
    @(posedge aclk);
    awaddr  <= a;
    awvalid <= 1'b1;
    wdata   <= {24'h000000, d};
    wvalid  <= 1'b1;
    b_go = 1'b0;
    while (!b_go)
    begin
      @(negedge aclk);
      aw_go = awvalid && awready;
      w_go  = wvalid && wready;
      b_go  = bvalid;
      r     = bresp;
      @(posedge aclk);
      if (aw_go) awvalid <= 1'b0;
      if (aw_go) awaddr <= ~a;
      if (w_go) wvalid <= 1'b0;
      if (w_go) wdata <= ~{24'h000000, d};
    end
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r,
                    output int lat);
    logic ar_go;
    logic r_go;
    @(posedge aclk);
    araddr  <= a;
    arvalid <= 1'b1;
    lat   = 0;
    ar_go = 1'b0;
    r_go  = 1'b0;
    while (!ar_go)
    begin
      @(negedge aclk);
      ar_go = arready;
      lat++;
      @(posedge aclk);
    end
    arvalid <= 1'b0;
    araddr  <= ~a;
    while (!r_go)
    begin
      @(negedge aclk);
      r_go = rvalid;
      d    = rdata;
      r    = rresp;
      @(posedge aclk);
    end
  endtask : rd
endmodule : node_host

// *** bench/token_node_setup_status_tb.sv ***
// bench: setup and status register scenarios
// assumes node_host as bus master and engine events as one-cycle pulses
`timescale 1ns/1ps
module token_node_setup_status_tb;
  logic        aclk, aresetn, clk_en, line_activity, receive_input, toggling;
  logic        awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready, nak_incoming, irq;
  logic        enhanced_timing_enable, init_write_allowed;
  logic [4:0]  ev;
  logic [2:0]  rate_shift;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata, rd_data;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp, rd_resp, clock_multiplier_select;
  int          rd_lat, err_count, tests_run;

  node_host i_host (.aclk(aclk), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready));

  token_node_setup_status #(.RCN_DIV(100000)) i_dut (.aclk(aclk), .aresetn(aresetn),
    .clk_en(clk_en), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .soft_reset(ev[0]), .rx_packet_done(ev[1]), .rx_disable_done(ev[2]),
    .tx_acked(ev[3]), .tx_done(ev[4]), .rate_shift(rate_shift),
    .line_activity(line_activity), .receive_input(receive_input),
    .clock_multiplier_select(clock_multiplier_select),
    .enhanced_timing_enable(enhanced_timing_enable),
    .init_write_allowed(init_write_allowed), .nak_incoming(nak_incoming), .irq(irq));

  initial
  begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end

  // line activity on the receive pin keeps the idle timer quiet
  always @(posedge aclk)
    if (toggling) receive_input <= ~receive_input;

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
    tests_run++;
    if (got !== ex)
    begin
      err_count++;
      $display("unexpected %s: expected %h, seen %h", nm, ex, got);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] ex);
    logic [1:0] r;
    i_host.wr(a, d, r);
    chk("bresp", {30'h0, ex}, {30'h0, r});
  endtask : wr

  task automatic rd(input logic [7:0] a);
    i_host.rd(a, rd_data, rd_resp, rd_lat);
  endtask : rd

  // bits 6 and 5 are left out of the compare
  task automatic st(input logic [7:0] ex);
    rd(node_pkg::OFF_NODE_STATUS);
    chk("status", {24'h0, ex}, rd_data & 32'h9f);
  endtask : st

  task automatic pulse(input logic [4:0] m);
    @(posedge aclk);
    ev <= m;
    @(posedge aclk);
    ev <= 5'h00;
  endtask : pulse

  task automatic chk_irq(input logic ex);
    @(negedge aclk);
    chk("irq", {31'h0, ex}, {31'h0, irq});
  endtask : chk_irq

  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic t_reset;
    st(8'h91);
    wr(node_pkg::OFF_SUB_SELECT, 8'h04, 2'h0);
    rd(node_pkg::OFF_SETUP_TWO);
    chk("setup_two", 32'h0, rd_data);
  endtask : t_reset

  task automatic t_setup;
    wr(node_pkg::OFF_SETUP_TWO, 8'hdb, 2'h0);
    rd(node_pkg::OFF_SETUP_TWO);
    chk("setup_two", 32'hdb, rd_data);
    @(negedge aclk);
    chk("clock_mult", 32'h3, {30'h0, clock_multiplier_select});
    chk("enhanced", 32'h1, {31'h0, enhanced_timing_enable});
    chk("init_write", 32'h1, {31'h0, init_write_allowed});
    wr(node_pkg::OFF_SETUP_TWO, 8'h04, 2'h0);
    @(negedge aclk);
    chk("init_write", 32'h0, {31'h0, init_write_allowed});
    chk("enhanced", 32'h0, {31'h0, enhanced_timing_enable});
    rd(node_pkg::OFF_SETUP_TWO);
    chk("fast_latency", 32'h1, rd_lat);
    line_activity <= 1'b0;
    @(negedge aclk);
    chk("init_write", 32'h1, {31'h0, init_write_allowed});
    @(posedge aclk);
    line_activity <= 1'b1;
    wr(node_pkg::OFF_SETUP_TWO, 8'h00, 2'h0);
    rd(node_pkg::OFF_SETUP_TWO);
    chk("slow_latency", 32'h2, rd_lat);
    wr(node_pkg::OFF_CONFIG, 8'h00, 2'h0);
    wr(node_pkg::OFF_SETUP_TWO, 8'h55, 2'h2);
    rd(8'h20);
    chk("unmapped_rresp", 32'h2, {30'h0, rd_resp});
  endtask : t_setup

  task automatic t_flags;
    wr(node_pkg::OFF_COMMAND, 8'h03, 2'h0);
    st(8'h90);
    pulse(5'h08);
    st(8'h92);
    pulse(5'h10);
    st(8'h93);
    wr(node_pkg::OFF_COMMAND, 8'h03, 2'h0);
    wr(node_pkg::OFF_COMMAND, 8'h01, 2'h0);
    st(8'h91);
    wr(node_pkg::OFF_COMMAND, 8'h04, 2'h0);
    st(8'h11);
    chk("nak", 32'h0, {31'h0, nak_incoming});
    pulse(5'h02);
    st(8'h91);
    chk("nak", 32'h1, {31'h0, nak_incoming});
    wr(node_pkg::OFF_COMMAND, 8'h04, 2'h0);
    pulse(5'h04);
    st(8'h91);
    wr(node_pkg::OFF_COMMAND, 8'h1e, 2'h0);
    st(8'h81);
    wr(node_pkg::OFF_NODE_ID, 8'h00, 2'h0);
    st(8'h91);
    wr(node_pkg::OFF_COMMAND, 8'h1e, 2'h0);
    pulse(5'h01);
    st(8'h91);
  endtask : t_flags

  task automatic t_irq;
    wr(node_pkg::OFF_MASK, 8'h01, 2'h0);
    chk_irq(1'b1);
    wr(node_pkg::OFF_COMMAND, 8'h03, 2'h0);
    chk_irq(1'b0);
    wr(node_pkg::OFF_MASK, 8'h80, 2'h0);
    chk_irq(1'b1);
    wr(node_pkg::OFF_MASK, 8'h00, 2'h0);
    chk_irq(1'b0);
    wr(node_pkg::OFF_COMMAND, 8'h01, 2'h0);
    wr(node_pkg::OFF_COMMAND, 8'h1e, 2'h0);
  endtask : t_irq

  // events lost while frozen, then a reset in mid-run
  task automatic t_freeze;
    clk_en <= 1'b0;
    pulse(5'h01);
    clk_en <= 1'b1;
    st(8'h81);
    wr(node_pkg::OFF_SUB_SELECT, 8'h04, 2'h0);
    wr(node_pkg::OFF_SETUP_TWO, 8'h5a, 2'h0);
    aresetn <= 1'b0;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    st(8'h91);
    wr(node_pkg::OFF_SUB_SELECT, 8'h04, 2'h0);
    rd(node_pkg::OFF_SETUP_TWO);
    chk("setup_two", 32'h0, rd_data);
    wr(node_pkg::OFF_COMMAND, 8'h1e, 2'h0);
  endtask : t_freeze

  task automatic t_recon;
    wr(node_pkg::OFF_SUB_SELECT, 8'h04, 2'h0);
    // shortest timeout: network assumed to hold a node 255
    wr(node_pkg::OFF_SETUP_TWO, 8'hc0, 2'h0);
    rate_shift <= 3'h1;
    toggling   <= 1'b0;
    repeat (40) @(posedge aclk);
    st(8'h81);
    repeat (80) @(posedge aclk);
    st(8'h85);
    wr(node_pkg::OFF_MASK, 8'h04, 2'h0);
    chk_irq(1'b1);
    toggling <= 1'b1;
    wr(node_pkg::OFF_COMMAND, 8'h1e, 2'h0);
    st(8'h81);
  endtask : t_recon

  task automatic wrap_up;
    $display("comparisons %0d, mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : wrap_up

  initial
  begin
    repeat (20000) @(posedge aclk);
    err_count++;
    wrap_up();
  end

  initial
  begin
    err_count     = 0;
    tests_run     = 0;
    aresetn       = 1'b0;
    clk_en        = 1'b1;
    ev            = 5'h00;
    rate_shift    = 3'h0;
    line_activity = 1'b1;
    receive_input = 1'b0;
    toggling      = 1'b1;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset();
    t_setup();
    t_flags();
    t_irq();
    t_freeze();
    t_recon();
    wrap_up();
  end
endmodule : token_node_setup_status_tb

// *** inc/node_pkg.sv ***
// package: register map, field layout, reset values and timing counts
// assumes a 100 mhz aclk and an axi4-lite register bus
package node_pkg;

  // register byte addresses (word aligned)
  localparam logic [7:0] OFF_SETUP_TWO   = 8'h00;
  localparam logic [7:0] OFF_NODE_STATUS = 8'h04;
  localparam logic [7:0] OFF_SUB_SELECT  = 8'h08;
  localparam logic [7:0] OFF_MASK        = 8'h0c;
  localparam logic [7:0] OFF_COMMAND     = 8'h10;
  localparam logic [7:0] OFF_CONFIG      = 8'h14;
  localparam logic [7:0] OFF_NODE_ID     = 8'h18;

  // sub-select code of the second setup register
  localparam logic [2:0] SUB_SETUP_TWO = 3'h4;

  // setup_two field positions
  localparam int MULT_LSB  = 0;
  localparam int FAST_BIT  = 2;
  localparam int ENH_BIT   = 3;
  localparam int SYNC_BIT  = 4;
  localparam int RCN_LSB   = 6;

  // status bit positions
  localparam int ST_INHIB = 7;
  localparam int ST_POR  = 4;
  localparam int ST_TEST = 3;
  localparam int ST_RCN  = 2;
  localparam int ST_TXACK = 1;
  localparam int ST_TXAV  = 0;

  // reset values
  localparam logic [7:0] SETUP_TWO_RST = 8'h00;
  localparam logic [7:0] STATUS_RST    = 8'h91;
  localparam logic [7:0] MASK_RST      = 8'h00;

  // command codes
  localparam logic [7:0] CMD_CLR_FLAGS = 8'h1e;
  localparam logic [7:0] CMD_TX_DIS    = 8'h01;
  localparam logic [7:0] CMD_RX_DIS    = 8'h02;
  localparam logic [2:0] CMD_RX_PAGE   = 3'h4;
  localparam logic [2:0] CMD_TX_PAGE   = 3'h3;

  // recon timeouts at 5 mbps, in microseconds
  localparam real RCN_US_0 = 420000.0;
  localparam real RCN_US_1 = 105000.0;
  localparam real RCN_US_2 = 52500.0;
  localparam real RCN_US_3 = 26250.0;
  localparam real CLK_MHZ  = 100.0;
  localparam int  RCN_CYC_0 = int'($floor(RCN_US_0 * CLK_MHZ));
  localparam int  RCN_CYC_1 = int'($floor(RCN_US_1 * CLK_MHZ));
  localparam int  RCN_CYC_2 = int'($floor(RCN_US_2 * CLK_MHZ));
  localparam int  RCN_CYC_3 = int'($floor(RCN_US_3 * CLK_MHZ));

  typedef struct packed {
    logic [1:0] recon_timeout_select;
    logic       spare;
    logic       idle_line_bypass;
    logic       enhanced_timing_enable;
    logic       fast_read_control;
    logic [1:0] clock_multiplier_select;
  } setup_two_s;

endpackage : node_pkg

// *** verilog/token_node_setup_status.sv ***
// setup two and status registers of a token-passing node, axi4-lite slave
// assumes protocol engine events arrive as one-cycle pulses on aclk
//
// How it works
// (RL1) setup two reached only at its sub-select code
// (RL2) clock multiplier field picks derived clock
// (RL3) fast read bit shortens read answer
// (RL4) enhanced timing bit selects new timing
// (RL5) idle bypass lets init ignore line
// (RL6) timeout field picks recon timer period
// (RL7) period scales with selected data rate
// (RL8) shortest timeout needs node 255 present
// (RL9) receiver inhibited cleared by receive command
// (RL10) inhibited receiver answers with negative ack
// (RL11) inhibit, recon, tx available raise masked interrupt
// (RL12) status bits six, five undefined
// (RL13) por flag set by resets, id zero
// (RL14) test bit reads zero
// (RL15) recon set on line idle timeout
// (RL16) tx ack set on ack, cleared by tx
// (RL17) tx available set on done or disable
// (RL18) status resets to 1xx1 0001
// (RL19) interrupt is or of masked bits
// (RL20) config write clears third sub-select bit
// (RL21) setup two resets to zero
`timescale 1ns/1ps
module token_node_setup_status #(
  parameter int RATE_SHIFT_MAX = 5,
  parameter int RCN_DIV        = 1
) (
  // clock, reset, enable
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        clk_en,
  // axi4-lite write
  input  wire logic [7:0]  awaddr,
  input  wire logic        awvalid,
  output      logic        awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output      logic        wready,
  output      logic [1:0]  bresp,
  output      logic        bvalid,
  input  wire logic        bready,
  // axi4-lite read
  input  wire logic [7:0]  araddr,
  input  wire logic        arvalid,
  output      logic        arready,
  output      logic [31:0] rdata,
  output      logic [1:0]  rresp,
  output      logic        rvalid,
  input  wire logic        rready,
  // protocol engine events
  input  wire logic        soft_reset,
  input  wire logic        rx_packet_done,
  input  wire logic        rx_disable_done,
  input  wire logic        tx_acked,
  input  wire logic        tx_done,
  input  wire logic [2:0]  rate_shift,
  input  wire logic        line_activity,
  // pins and engine controls
  input  wire logic        receive_input,
  output      logic [1:0]  clock_multiplier_select,
  output      logic        enhanced_timing_enable,
  output      logic        init_write_allowed,
  output      logic        nak_incoming,
  output      logic        irq
);

  if (RATE_SHIFT_MAX < 0 || RATE_SHIFT_MAX > 6 || RCN_DIV < 1)
  begin : g_bad_params
    $error("bad parameters");
  end

  // ---------------------------------------------------------------
  // registers and synchronisers
  // ---------------------------------------------------------------
  node_pkg::setup_two_s setup_two;
  logic [7:0]  node_status;
  logic [2:0]  sub_select_bits;
  logic [7:0]  interrupt_mask_reg;
  logic [7:0]  config_reg;
  logic [7:0]  node_id;
  logic [1:0]  rx_pin_sync;
  logic        rx_pin_prev;
  logic [31:0] idle_count;
  logic        rd_wait;
  logic        aw_held;
  logic        w_held;
  logic [7:0]  aw_addr_q;
  logic [31:0] w_data_q;
  logic [3:0]  w_strb_q;

  // ---------------------------------------------------------------
  // write path decode
  // ---------------------------------------------------------------
  wire       aw_have   = aw_held | awvalid;
  wire       w_have    = w_held | wvalid;
  wire [7:0] wr_addr   = aw_held ? aw_addr_q : awaddr;
  wire [31:0] wr_data  = w_held ? w_data_q : wdata;
  wire [3:0] wr_strb   = w_held ? w_strb_q : wstrb;
  wire       wr_fire   = clk_en & aw_have & w_have & ~bvalid;
  wire       wr_lane0  = wr_fire & wr_strb[0];
  wire [7:0] wr_byte   = wr_data[7:0];
  // (RL1) access gated by the sub-select code
  wire       setup_sel = sub_select_bits == node_pkg::SUB_SETUP_TWO;
  wire       wr_setup  = wr_lane0 & (wr_addr == node_pkg::OFF_SETUP_TWO) & setup_sel;
  wire       wr_sub    = wr_lane0 & (wr_addr == node_pkg::OFF_SUB_SELECT);
  wire       wr_mask   = wr_lane0 & (wr_addr == node_pkg::OFF_MASK);
  wire       wr_cmd    = wr_lane0 & (wr_addr == node_pkg::OFF_COMMAND);
  wire       wr_cfg    = wr_lane0 & (wr_addr == node_pkg::OFF_CONFIG);
  wire       wr_nid    = wr_lane0 & (wr_addr == node_pkg::OFF_NODE_ID);
  wire       wr_known  = (wr_addr == node_pkg::OFF_SETUP_TWO && setup_sel)
                       | wr_addr == node_pkg::OFF_SUB_SELECT | wr_addr == node_pkg::OFF_MASK
                       | wr_addr == node_pkg::OFF_COMMAND | wr_addr == node_pkg::OFF_CONFIG
                       | wr_addr == node_pkg::OFF_NODE_ID;

  // command decode
  wire cmd_clr   = wr_cmd & (wr_byte == node_pkg::CMD_CLR_FLAGS);
  wire cmd_txdis = wr_cmd & (wr_byte == node_pkg::CMD_TX_DIS);
  wire cmd_rxpg  = wr_cmd & (wr_byte[2:0] == node_pkg::CMD_RX_PAGE) & ~wr_byte[6];
  wire cmd_txpg  = wr_cmd & (wr_byte[2:0] == node_pkg::CMD_TX_PAGE) & (wr_byte[7:6] == 2'h0);
  wire id_zero   = wr_nid & (wr_byte == 8'h00);

  assign awready = clk_en & ~aw_held & ~bvalid;
  assign wready  = clk_en & ~w_held & ~bvalid;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_held   <= 1'b0;
      w_held    <= 1'b0;
      aw_addr_q <= 8'h00;
      w_data_q  <= 32'h0;
      w_strb_q  <= 4'h0;
      bvalid    <= 1'b0;
      bresp     <= 2'h0;
    end
    else if (clk_en)
    begin
      if (awvalid && awready)
      begin
        aw_held   <= ~wr_fire;
        aw_addr_q <= awaddr;
      end
      if (wvalid && wready)
      begin
        w_held   <= ~wr_fire;
        w_data_q <= wdata;
        w_strb_q <= wstrb;
      end
      if (wr_fire)
      begin
        aw_held <= 1'b0;
        w_held  <= 1'b0;
        bvalid  <= 1'b1;
        bresp   <= wr_known ? 2'h0 : 2'h2;
      end
      else if (bready)
        bvalid <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // control registers
  // ---------------------------------------------------------------
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      // (RL21) setup two zero after reset
      setup_two          <= node_pkg::SETUP_TWO_RST;
      sub_select_bits    <= 3'h0;
      interrupt_mask_reg <= node_pkg::MASK_RST;
      config_reg         <= 8'h18;
      node_id            <= 8'h00;
    end
    else if (clk_en)
    begin
      if (wr_setup)
        setup_two <= wr_byte;
      if (wr_mask)
        interrupt_mask_reg <= wr_byte;
      if (wr_nid)
        node_id <= wr_byte;
      if (wr_cfg)
        config_reg <= wr_byte;
      // (RL20) config write drops third sub-select bit
      if (wr_cfg)
        sub_select_bits <= {1'b0, wr_byte[1:0]};
      else if (wr_sub)
        sub_select_bits <= wr_byte[2:0];
    end
  end

  // (RL2) clock multiplier select driven out
  assign clock_multiplier_select = setup_two.clock_multiplier_select;
  // (RL4) enhanced timing selection driven out
  assign enhanced_timing_enable  = setup_two.enhanced_timing_enable;
  // (RL5) init write needs idle line unless bypassed
  assign init_write_allowed = setup_two.idle_line_bypass | ~line_activity;

  // ---------------------------------------------------------------
  // recon line idle timer
  // ---------------------------------------------------------------
  wire rx_pin_edge = rx_pin_sync[1] ^ rx_pin_prev;
  // (RL6) period picked by timeout field
  wire [31:0] base_cycles =
      setup_two.recon_timeout_select == 2'h0 ? 32'(node_pkg::RCN_CYC_0 / RCN_DIV) :
      setup_two.recon_timeout_select == 2'h1 ? 32'(node_pkg::RCN_CYC_1 / RCN_DIV) :
      setup_two.recon_timeout_select == 2'h2 ? 32'(node_pkg::RCN_CYC_2 / RCN_DIV) :
                                               32'(node_pkg::RCN_CYC_3 / RCN_DIV);
  // (RL7) slower rates lengthen the period by powers of two
  wire [2:0]  shift_used   = rate_shift > 3'(RATE_SHIFT_MAX) ? 3'(RATE_SHIFT_MAX) : rate_shift;
  wire [31:0] limit_cycles = base_cycles << shift_used;
  wire        idle_expire  = (idle_count + 32'h1 >= limit_cycles) & ~rx_pin_edge;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rx_pin_sync <= 2'h0;
      rx_pin_prev <= 1'b0;
      idle_count <= 32'h0;
    end
    else if (clk_en)
    begin
      rx_pin_sync <= {rx_pin_sync[0], receive_input};
      rx_pin_prev <= rx_pin_sync[1];
      idle_count  <= (rx_pin_edge || idle_expire) ? 32'h0 : idle_count + 32'h1;
    end
  end

  // ---------------------------------------------------------------
  // status flags, sets win over clears
  // ---------------------------------------------------------------
  logic [7:0] next_status;
  always_comb
  begin
    next_status = node_status;
    // (RL9) inhibited cleared by receive command, set on packet
    if (cmd_rxpg)
      next_status[node_pkg::ST_INHIB] = 1'b0;
    if (rx_packet_done || rx_disable_done)
      next_status[node_pkg::ST_INHIB] = 1'b1;
    // (RL13) por flag
    if (cmd_clr)
      next_status[node_pkg::ST_POR] = 1'b0;
    if (id_zero || soft_reset)
      next_status[node_pkg::ST_POR] = 1'b1;
    // (RL15) recon flag
    if (cmd_clr)
      next_status[node_pkg::ST_RCN] = 1'b0;
    if (idle_expire)
      next_status[node_pkg::ST_RCN] = 1'b1;
    // (RL16) tx acknowledged
    if (cmd_txpg)
      next_status[node_pkg::ST_TXACK] = 1'b0;
    if (tx_acked)
      next_status[node_pkg::ST_TXACK] = 1'b1;
    // (RL17) tx available
    if (cmd_txpg)
      next_status[node_pkg::ST_TXAV] = 1'b0;
    if (tx_done || cmd_txdis)
      next_status[node_pkg::ST_TXAV] = 1'b1;
    // (RL12) undefined bits held at zero
    next_status[6:5] = 2'h0;
    // (RL14) test bit
    next_status[node_pkg::ST_TEST] = 1'b0;
  end

  always_ff @(posedge aclk)
  begin
    // (RL18) reset value 1xx1 0001
    if (!aresetn)
      node_status <= node_pkg::STATUS_RST;
    else if (clk_en)
      node_status <= next_status;
  end

  // (RL10) inhibited receiver naks incoming packets
  assign nak_incoming = node_status[node_pkg::ST_INHIB];

  // (RL11) masked interrupt sources
  wire [7:0] irq_src = {node_status[node_pkg::ST_INHIB], 4'h0, node_status[node_pkg::ST_RCN],
                        1'b0, node_status[node_pkg::ST_TXAV]};
  // (RL19) or of masked bits
  assign irq = |(irq_src & interrupt_mask_reg);

  // ---------------------------------------------------------------
  // read path
  // ---------------------------------------------------------------
  wire [7:0] rd_byte =
      (araddr == node_pkg::OFF_SETUP_TWO && setup_sel) ? setup_two :
      araddr == node_pkg::OFF_NODE_STATUS ? node_status :
      araddr == node_pkg::OFF_SUB_SELECT  ? {5'h0, sub_select_bits} :
      araddr == node_pkg::OFF_MASK        ? interrupt_mask_reg :
      araddr == node_pkg::OFF_CONFIG      ? config_reg :
      araddr == node_pkg::OFF_NODE_ID     ? node_id : 8'h00;
  wire rd_known = (araddr == node_pkg::OFF_SETUP_TWO && setup_sel)
                | araddr == node_pkg::OFF_NODE_STATUS | araddr == node_pkg::OFF_SUB_SELECT
                | araddr == node_pkg::OFF_MASK | araddr == node_pkg::OFF_CONFIG
                | araddr == node_pkg::OFF_NODE_ID | araddr == node_pkg::OFF_COMMAND;

  // (RL3) slow mode takes one extra wait cycle
  assign arready = clk_en & arvalid & ~rvalid & (setup_two.fast_read_control | rd_wait);

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rvalid  <= 1'b0;
      rdata   <= 32'h0;
      rresp   <= 2'h0;
      rd_wait <= 1'b0;
    end
    else if (clk_en)
    begin
      rd_wait <= arvalid & ~rvalid & ~arready;
      if (arready)
      begin
        rvalid <= 1'b1;
        rdata  <= {24'h0, rd_byte};
        rresp  <= rd_known ? 2'h0 : 2'h2;
      end
      else if (rready)
        rvalid <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  a_inhib_clear_cmd: assert property (@(posedge aclk) disable iff (!aresetn) // (RL9)
    clk_en && cmd_rxpg && !rx_packet_done && !rx_disable_done |=> !node_status[7])
    else $error("inhibit not cleared by receive command");
  a_inhib_set_pkt: assert property (@(posedge aclk) disable iff (!aresetn) // (RL9)
    clk_en && rx_packet_done |=> node_status[7])
    else $error("inhibit not set on packet");
  a_nak_follows: assert property (@(posedge aclk) disable iff (!aresetn) // (RL10)
    clk_en && rx_packet_done |=> nak_incoming)
    else $error("no nak after packet landed");
  a_irq_masked: assert property (@(posedge aclk) disable iff (!aresetn) // (RL19)
    irq == ((node_status[7] & interrupt_mask_reg[7]) | (node_status[2] & interrupt_mask_reg[2])
            | (node_status[0] & interrupt_mask_reg[0])))
    else $error("irq mismatch");
  a_por_id_zero: assert property (@(posedge aclk) disable iff (!aresetn) // (RL13)
    clk_en && id_zero |=> node_status[4])
    else $error("por not set on zero id");
  a_txav_set: assert property (@(posedge aclk) disable iff (!aresetn) // (RL17)
    clk_en && (tx_done || cmd_txdis) |=> node_status[0])
    else $error("tx available not set");
  a_txack_clear: assert property (@(posedge aclk) disable iff (!aresetn) // (RL16)
    clk_en && cmd_txpg && !tx_acked && !tx_done |=> !node_status[1] && !node_status[0])
    else $error("tx acknowledged not cleared");
  a_cfg_sub_clr: assert property (@(posedge aclk) disable iff (!aresetn) // (RL20)
    clk_en && wr_cfg |=> !sub_select_bits[2])
    else $error("sub bit two not cleared");
  a_test_zero: assert property (@(posedge aclk) disable iff (!aresetn) // (RL14)
    !node_status[3] && node_status[6:5] == 2'h0)
    else $error("test or reserved bits set");
  a_recon_set: assert property (@(posedge aclk) disable iff (!aresetn) // (RL15)
    clk_en && idle_expire |=> node_status[2])
    else $error("recon not set");

endmodule : token_node_setup_status
